// ### inc/tfr_pkg.sv
`default_nettype none
package tfr_pkg;
   // ==========================================================
   // Register indices (byte address is four times the index)
   localparam logic [9:0] CAS_FLAGS_IDX = 10'h10F;
   localparam logic [9:0] FRAME_STAT_IDX = 10'h110;
   localparam logic [9:0] DL_CTRL_IDX = 10'h113;
   // ==========================================================
   // Field positions and reset values
   localparam int IN_FRAME_BIT = 7;
   localparam int LINK_ON_BIT = 7;
   localparam int ABORT_OFF_BIT = 6;
   localparam int CHECK_OFF_BIT = 5;
   localparam logic [7:0] CAS_FLAGS_RST = 8'h00;
   localparam logic [2:0] DL_CTRL_RST = 3'h0;
   localparam logic [7:0] DL_CTRL_MASK = 8'hE0;
   // ==========================================================
   // Abort sequence: sent LSB first, one zero then seven ones
   localparam logic [7:0] ABORT_PATTERN = 8'hFE;
   localparam logic [3:0] ABORT_LEN = 4'h8;
   // ==========================================================
   // Frame check: reflected CCITT polynomial and good residue
   localparam logic [15:0] CRC_POLY = 16'h8408;
   localparam logic [15:0] CRC_INIT = 16'hFFFF;
   localparam logic [15:0] CRC_GOOD = 16'hF0B8;
   // ==========================================================
   // Framing formats reported by the receive framer
   typedef enum logic [1:0] {
      TFR_FMT_SF = 2'h0,
      TFR_FMT_ESF = 2'h1,
      TFR_FMT_LOOP = 2'h2,
      TFR_FMT_OTHER = 2'h3
   } tfr_fmt_e;
   // One received signaling word for a timeslot of 16..23
   typedef struct packed {
      logic valid;
      logic [2:0] slot;
      logic [3:0] sig;
   } tfr_cas_s;
   // One received data-link bit of a message frame
   typedef struct packed {
      logic valid;
      logic first;
      logic last;
      logic data;
   } tfr_rxbit_s;
endpackage
`default_nettype wire

// ### rtl/tfr_cas_mem.sv
`default_nettype none
module tfr_cas_mem #(
   parameter int SLOTS = 8,
   parameter int SIG_W = 4
) (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Received signaling
   input wire logic cas_active,
   input wire logic wr_en,
   input wire logic [$clog2(SLOTS)-1:0] wr_slot,
   input wire logic [SIG_W-1:0] wr_sig,
   // Change pulses, MSB is the lowest timeslot
   output logic [SLOTS-1:0] chg_r
);
   import tfr_pkg::*;

   // Elaboration check: the bit mapping assumes exactly eight slots
   if (SLOTS != 8 || SIG_W < 1) begin : g_bad_param
      $error("tfr_cas_mem needs SLOTS of 8 and SIG_W of 1 or more");
   end

   logic [SIG_W-1:0] mem_r [SLOTS];

   // =======================================================
   // Last signaling word per slot; tracked even without CAS
   // so that turning CAS on does not flag stale history
   genvar g;
   generate
      for (g = 0; g < SLOTS; g++) begin : g_slot
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               mem_r[g] <= '0;
            end else if (wr_en && wr_slot == g) begin
               mem_r[g] <= wr_sig;
            end
         end
         // Change pulse, registered; slot 0 lands on the MSB
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               chg_r[SLOTS-1-g] <= 1'b0;
            end else begin
               chg_r[SLOTS-1-g] <= cas_active && wr_en && wr_slot == g
                  && mem_r[g] != wr_sig;
            end
         end
      end
   endgenerate
endmodule
`default_nettype wire

// ### rtl/tfr_regs.sv
`default_nettype none
module tfr_regs #(
   parameter int ADDR_W = 12
) (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic pready,
   output logic pslverr,
   output logic [31:0] prdata,
   // Receive framer state
   input wire logic in_frame,
   input wire logic cas_active,
   input wire tfr_pkg::tfr_fmt_e frame_fmt,
   input wire tfr_pkg::tfr_cas_s cas_in,
   // Transmit HDLC controller 1
   input wire logic tx_bit_tick,
   input wire logic tx_mos,
   input wire logic tx_msg_active,
   output logic tx_abort_busy,
   output logic tx_abort_bit,
   // Receive HDLC controller 1
   input wire tfr_pkg::tfr_rxbit_s rx_bit,
   output logic rx_fcs_ok,
   output logic rx_fcs_err,
   // Framing control
   output logic loop_carrier_link_on,
   output logic tx_sf_fbits
);
   import tfr_pkg::*;

   // Elaboration check: the register indices need twelve address bits
   if (ADDR_W < 12) begin : g_bad_param
      $error("tfr_regs needs ADDR_W of 12 or more");
   end

   // =======================================================
   // Address decode
   function automatic logic hit(input logic [ADDR_W-1:0] a,
                                input logic [9:0] idx);
      hit = a[1:0] == 2'h0 && a[ADDR_W-1:2] == (ADDR_W-2)'(idx);
   endfunction

   function automatic logic [15:0] crc_step(input logic [15:0] c,
                                            input logic b);
      crc_step = (c[0] ^ b) ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
   endfunction

   logic setup;
   logic access;
   logic mapped;
   logic [7:0] rd_byte;
   logic [7:0] cas_chg;
   logic [7:0] cas_flags_r;
   logic [7:0] cas_taken_r;
   logic [2:0] dl_ctrl_r;
   logic [31:0] prdata_r;
   logic pslverr_r;
   logic auto_abort_off;
   logic rx_check_sequence_off;
   logic fmt_allows_link;
   logic tx_mos_r;
   logic abrupt;
   logic [7:0] abort_sr_r;
   logic [3:0] abort_cnt_r;
   logic [15:0] crc_r;
   logic [15:0] crc_nxt;
   logic fcs_ok_r;
   logic fcs_err_r;

   assign setup = psel && !penable;
   assign access = psel && penable;
   assign mapped = hit(paddr, CAS_FLAGS_IDX) || hit(paddr, FRAME_STAT_IDX)
      || hit(paddr, DL_CTRL_IDX);

   // Zero wait states; data and error registered at setup
   assign pready = 1'b1;
   assign prdata = prdata_r;
   assign pslverr = pslverr_r;

   // =======================================================
   // Signaling change detection for timeslots 16..23
   tfr_cas_mem #(
      .SLOTS(8),
      .SIG_W(4)
   ) u_cas_mem (
      .pclk(pclk),
      .presetn(presetn),
      .cas_active(cas_active),
      .wr_en(cas_in.valid),
      .wr_slot(cas_in.slot),
      .wr_sig(cas_in.sig),
      .chg_r(cas_chg)
   );

   // Read mux; bits 6..0 of frame status tie to zero
   always_comb begin
      rd_byte = 8'h00;
      if (hit(paddr, CAS_FLAGS_IDX)) begin
         rd_byte = cas_flags_r;
      end else if (hit(paddr, FRAME_STAT_IDX)) begin
         rd_byte[IN_FRAME_BIT] = in_frame;
      end else if (hit(paddr, DL_CTRL_IDX)) begin
         rd_byte = {dl_ctrl_r, 5'h00};
      end
   end

   // =======================================================
   // Read data and error captured in the setup cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_r <= 32'h0000_0000;
         pslverr_r <= 1'b0;
      end else if (setup) begin
         prdata_r <= pwrite ? 32'h0000_0000 : {24'h00_0000, rd_byte};
         pslverr_r <= !mapped;
      end
   end

   // Flags shown to the reader; only these are cleared later
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cas_taken_r <= 8'h00;
      end else if (setup) begin
         cas_taken_r <= (!pwrite && hit(paddr, CAS_FLAGS_IDX))
            ? cas_flags_r : 8'h00;
      end
   end

   // Sticky flags: clear-on-read of shown bits, a new change wins
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cas_flags_r <= CAS_FLAGS_RST;
      end else if (access && !pwrite) begin
         cas_flags_r <= (cas_flags_r & ~cas_taken_r) | cas_chg;
      end else begin
         cas_flags_r <= cas_flags_r | cas_chg;
      end
   end

   // =======================================================
   // Data-link control bits 7..5; bits 4..0 read as zero
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         dl_ctrl_r <= DL_CTRL_RST;
      end else if (access && pwrite && pstrb[0]
                   && hit(paddr, DL_CTRL_IDX)) begin
         dl_ctrl_r <= pwdata[LINK_ON_BIT:CHECK_OFF_BIT];
      end
   end

   assign auto_abort_off = dl_ctrl_r[ABORT_OFF_BIT-CHECK_OFF_BIT];
   assign rx_check_sequence_off = dl_ctrl_r[0];

   // Link enable is ignored outside loop-carrier and ESF formats
   assign fmt_allows_link = frame_fmt == TFR_FMT_LOOP
      || frame_fmt == TFR_FMT_ESF;
   assign loop_carrier_link_on = dl_ctrl_r[LINK_ON_BIT-CHECK_OFF_BIT]
      && fmt_allows_link;
   assign tx_sf_fbits = !loop_carrier_link_on;

   // =======================================================
   // Automatic abort on an abrupt message-to-bit switch
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tx_mos_r <= 1'b0;
      end else begin
         tx_mos_r <= tx_mos;
      end
   end

   // Abrupt means a message was still going out at the switch
   assign abrupt = tx_mos_r && !tx_mos && tx_msg_active;

   // Shift register holds the pattern; a new switch restarts it
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         abort_sr_r <= 8'hFF;
         abort_cnt_r <= 4'h0;
      end else if (abrupt && !auto_abort_off) begin
         abort_sr_r <= ABORT_PATTERN;
         abort_cnt_r <= ABORT_LEN;
      end else if (tx_bit_tick && abort_cnt_r != 4'h0) begin
         abort_sr_r <= {1'b1, abort_sr_r[7:1]};
         abort_cnt_r <= abort_cnt_r - 4'h1;
      end
   end

   assign tx_abort_busy = abort_cnt_r != 4'h0;
   assign tx_abort_bit = abort_sr_r[0];

   // =======================================================
   // Receive frame check; residue tested on the last bit
   always_comb begin
      crc_nxt = crc_step(rx_bit.first ? CRC_INIT : crc_r, rx_bit.data);
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         crc_r <= CRC_INIT;
      end else if (rx_bit.valid) begin
         crc_r <= crc_nxt;
      end
   end

   // One-cycle verdicts; both stay low while checking is off
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fcs_ok_r <= 1'b0;
         fcs_err_r <= 1'b0;
      end else begin
         fcs_ok_r <= rx_bit.valid && rx_bit.last && !rx_check_sequence_off
            && crc_nxt == CRC_GOOD;
         fcs_err_r <= rx_bit.valid && rx_bit.last && !rx_check_sequence_off
            && crc_nxt != CRC_GOOD;
      end
   end

   assign rx_fcs_ok = fcs_ok_r;
   assign rx_fcs_err = fcs_err_r;

   // =======================================================
   // Assertions
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   flag_latch_a: assert property (
      (|cas_chg) |=> ((cas_flags_r & $past(cas_chg)) == $past(cas_chg)))
      else $error("change pulse did not set its flag");

   read_clear_a: assert property (
      (access && !pwrite && hit(paddr, CAS_FLAGS_IDX) && cas_chg == 8'h00)
      |=> (cas_flags_r & $past(cas_taken_r)) == 8'h00)
      else $error("read flags were not cleared");

   read_shows_a: assert property (
      (setup && !pwrite && hit(paddr, CAS_FLAGS_IDX))
      |=> prdata_r == {24'h00_0000, $past(cas_flags_r)})
      else $error("flag read returned wrong value");

   cas_quiet_a: assert property (
      (!cas_active ##1 !(access && !pwrite)) |-> ##1
      (cas_flags_r == $past(cas_flags_r)))
      else $error("flags moved while signaling inactive");

   frame_bit_a: assert property (
      (setup && !pwrite && hit(paddr, FRAME_STAT_IDX))
      |=> prdata_r[7] == $past(in_frame) && pready)
      else $error("frame status bit wrong");

   stat_reserved_a: assert property (
      (setup && !pwrite && hit(paddr, FRAME_STAT_IDX))
      |=> prdata_r[6:0] == 7'h00)
      else $error("reserved frame status bits not zero");

   link_format_a: assert property (
      !(frame_fmt inside {TFR_FMT_LOOP, TFR_FMT_ESF})
      |-> !loop_carrier_link_on && tx_sf_fbits)
      else $error("link enabled in wrong format");

   link_follow_a: assert property (
      (access && pwrite && pstrb[0] && hit(paddr, DL_CTRL_IDX)
       && fmt_allows_link ##1 fmt_allows_link)
      |-> loop_carrier_link_on == $past(pwdata[7]))
      else $error("link enable did not follow write");

   abort_start_a: assert property (
      (abrupt && !auto_abort_off)
      |=> tx_abort_busy && !tx_abort_bit && abort_cnt_r == ABORT_LEN)
      else $error("abort did not start with a zero");

   abort_ones_a: assert property (
      (tx_abort_busy && tx_bit_tick && !abrupt)
      |=> tx_abort_bit)
      else $error("abort tail not all ones");

   abort_off_a: assert property (
      (abrupt && auto_abort_off && !tx_abort_busy)
      |=> !tx_abort_busy)
      else $error("abort sent while disabled");

   fcs_verdict_a: assert property (
      (rx_bit.valid && rx_bit.last && !rx_check_sequence_off)
      |=> rx_fcs_ok != rx_fcs_err
          && rx_fcs_ok == ($past(crc_nxt) == CRC_GOOD))
      else $error("frame check verdict wrong");

   fcs_off_a: assert property (
      rx_check_sequence_off |=> !rx_fcs_ok && !rx_fcs_err)
      else $error("frame check reported while disabled");
endmodule
`default_nettype wire

// ### dv/tfr_far_model.sv
`default_nettype none
module tfr_far_model (
   // Clock
   input wire logic pclk,
   // Line side towards the block
   output tfr_pkg::tfr_rxbit_s rx_bit,
   output logic tx_bit_tick
);
   timeunit 1ns;
   timeprecision 1ps;
   import tfr_pkg::*;
   // ==========================================================
   // Idle line
   initial begin
      rx_bit = '0;
      tx_bit_tick = 1'b0;
   end
   // One strobed bit; the data line then shows the inverse
   task automatic send_bit(input logic d, input logic f, input logic l);
      @(posedge pclk);
      rx_bit <= '{1'b1, f, l, d};
      @(posedge pclk);
      rx_bit <= '{1'b0, 1'b0, 1'b0, ~d};
   endtask
   // One data byte plus its check sequence, LSB first
   task automatic send_frame(input logic [7:0] dat, input logic bad);
      logic [15:0] crc;
      logic [23:0] fr;
      crc = CRC_INIT;
      for (int i = 0; i < 8; i++) begin
         crc = (crc >> 1) ^ ((crc[0] ^ dat[i]) ? CRC_POLY : 16'h0000);
      end
      fr = {~crc, dat};
      // A bad frame has one data bit flipped after the sum is taken
      fr[3] = fr[3] ^ bad;
      for (int i = 0; i < 24; i++) begin
         send_bit(fr[i], i == 0, i == 23);
      end
   endtask
   // One transmit bit period
   task automatic tick();
      @(posedge pclk);
      tx_bit_tick <= 1'b1;
      @(posedge pclk);
      tx_bit_tick <= 1'b0;
   endtask
endmodule
`default_nettype wire

// ### dv/t1_cas_frame_datalink_regs_tb_top.sv
`default_nettype none
module t1_cas_frame_datalink_regs_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import tfr_pkg::*;
   // ==========================================================
   // Signals
   localparam logic [11:0] A_FLG = {CAS_FLAGS_IDX, 2'b00};
   localparam logic [11:0] A_STA = {FRAME_STAT_IDX, 2'b00};
   localparam logic [11:0] A_CTL = {DL_CTRL_IDX, 2'b00};
   logic pclk = 1'b0, presetn = 1'b0;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = '0;
   logic [31:0] pwdata = '0, prdata, rd;
   logic [3:0] pstrb = 4'hF;
   logic pready, pslverr, er;
   logic in_frame = 1'b0, cas_active = 1'b0;
   logic tx_mos = 1'b0, tx_msg_active = 1'b0;
   tfr_fmt_e frame_fmt = TFR_FMT_SF;
   tfr_cas_s cas_in = '0;
   tfr_rxbit_s rx_bit;
   logic tx_bit_tick, tx_abort_busy, tx_abort_bit, rx_fcs_ok, rx_fcs_err;
   logic loop_carrier_link_on, tx_sf_fbits;
   int errors = 0, cmp_count = 0, ok_n = 0, err_n = 0;
   // ==========================================================
   // Clock, block and far side
   always #2 pclk = ~pclk;
   tfr_regs tfr_regs_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .pstrb(pstrb), .pready(pready), .pslverr(pslverr), .prdata(prdata),
      .in_frame(in_frame), .cas_active(cas_active), .frame_fmt(frame_fmt),
      .cas_in(cas_in), .tx_bit_tick(tx_bit_tick), .tx_mos(tx_mos),
      .tx_msg_active(tx_msg_active), .tx_abort_busy(tx_abort_busy),
      .tx_abort_bit(tx_abort_bit), .rx_bit(rx_bit), .rx_fcs_ok(rx_fcs_ok),
      .rx_fcs_err(rx_fcs_err), .loop_carrier_link_on(loop_carrier_link_on),
      .tx_sf_fbits(tx_sf_fbits));
   tfr_far_model tfr_far_model_inst (.pclk(pclk), .rx_bit(rx_bit),
      .tx_bit_tick(tx_bit_tick));
   // Pulses last one cycle, so they are counted at every edge
   always @(posedge pclk) begin
      if (rx_fcs_ok === 1'b1) ok_n++;
      if (rx_fcs_err === 1'b1) err_n++;
   end
   // ==========================================================
   // Shared tasks
   task automatic chk(input string nm, input logic [31:0] e,
                      input logic [31:0] g);
      cmp_count++;
      if (g !== e) begin
         errors++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (pready !== 1'b1) begin
         errors++;
         $display("Error pready expected 1 seen %b", pready);
      end
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rchk(input string nm, input logic [11:0] a,
                       input logic [7:0] e);
      apb(1'b0, a, '0);
      chk(nm, {24'h0, e}, rd);
   endtask
   task automatic cas(input logic [2:0] s, input logic [3:0] v);
      @(posedge pclk);
      cas_in <= '{1'b1, s, v};
      @(posedge pclk);
      cas_in <= '{1'b0, ~s, ~v};
      repeat (2) @(posedge pclk);
   endtask
   // Abrupt switch from message to bit oriented traffic
   task automatic switch_mode();
      @(posedge pclk);
      tx_msg_active <= 1'b1;
      tx_mos <= 1'b1;
      repeat (2) @(posedge pclk);
      tx_mos <= 1'b0;
      @(posedge pclk);
      #1;
   endtask
   // ==========================================================
   // Scenarios
   task automatic t_reset();
      rchk("flags", A_FLG, CAS_FLAGS_RST);
      rchk("ctrl", A_CTL, 8'h00);
      chk("link", 0, loop_carrier_link_on);
      $display("test reset done");
   endtask
   task automatic t_cas();
      cas_active <= 1'b1;
      cas(3'h0, 4'h5);
      cas(3'h7, 4'h3);
      cas(3'h3, 4'h0);
      rchk("flags", A_FLG, 8'h81);
      rchk("flags again", A_FLG, 8'h00);
      cas_active <= 1'b0;
      cas(3'h2, 4'h9);
      rchk("flags off", A_FLG, 8'h00);
      $display("test cas done");
   endtask
   task automatic t_status();
      in_frame <= 1'b1;
      rchk("in frame", A_STA, 8'h80);
      in_frame <= 1'b0;
      rchk("frame loss", A_STA, 8'h00);
      apb(1'b0, 12'h000, '0);
      chk("unmapped", 1, er);
      $display("test status done");
   endtask
   task automatic t_ctrl();
      apb(1'b1, A_CTL, 32'hFFFF_FFFF);
      rchk("ctrl", A_CTL, DL_CTRL_MASK);
      pstrb <= 4'hE;
      apb(1'b1, A_CTL, 32'h0);
      pstrb <= 4'hF;
      rchk("ctrl no lane", A_CTL, DL_CTRL_MASK);
      for (int f = 0; f < 4; f++) begin
         frame_fmt <= tfr_fmt_e'(f);
         repeat (2) @(posedge pclk);
         chk("link", f == 1 || f == 2, loop_carrier_link_on);
         chk("sf bits", !(f == 1 || f == 2), tx_sf_fbits);
      end
      apb(1'b1, A_CTL, 32'h0);
      repeat (2) @(posedge pclk);
      chk("link off", 0, loop_carrier_link_on);
      $display("test ctrl done");
   endtask
   task automatic t_abort();
      switch_mode();
      chk("busy", 1, tx_abort_busy);
      for (int i = 0; i < 8; i++) begin
         chk("abort bit", ABORT_PATTERN[i], tx_abort_bit);
         tfr_far_model_inst.tick();
         #1;
      end
      chk("busy end", 0, tx_abort_busy);
      apb(1'b1, A_CTL, 32'h40);
      switch_mode();
      repeat (3) @(posedge pclk);
      chk("busy off", 0, tx_abort_busy);
      $display("test abort done");
   endtask
   task automatic t_fcs();
      apb(1'b1, A_CTL, 32'h0);
      tfr_far_model_inst.send_frame(8'hA5, 1'b0);
      tfr_far_model_inst.send_frame(8'h3C, 1'b1);
      repeat (3) @(posedge pclk);
      chk("fcs ok", 1, ok_n);
      chk("fcs err", 1, err_n);
      apb(1'b1, A_CTL, 32'h20);
      tfr_far_model_inst.send_frame(8'h3C, 1'b1);
      repeat (3) @(posedge pclk);
      chk("fcs off", 1, err_n + ok_n - 1);
      $display("test fcs done");
   endtask
   // ==========================================================
   // Verdict and main sequence
   task automatic print_verdict();
      $display("comparisons %0d mismatches %0d", cmp_count, errors);
      if (errors == 0 && cmp_count > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   initial begin
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      t_reset();
      t_cas();
      t_status();
      t_ctrl();
      t_abort();
      t_fcs();
      print_verdict();
   end
   // Hang guard, far beyond the few hundred cycles used
   initial begin
      #100000;
      errors++;
      print_verdict();
   end
endmodule
`default_nettype wire
